//--- hw/sram_burst_port.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RQ1: Store enable low at rise starts write
// RQ2: Write address taken at following inverted edge
// RQ3: Each write stores two words, consecutive addresses
// RQ4: First write word taken with command edge
// RQ5: Second word taken at next inverted edge
// RQ6: Back-to-back writes take data every edge
// RQ7: Store enable high deselects, data ignored
// RQ8: Low mask writes lane, all high none
// RQ9: Wide organisation: four masks, four lanes
// RQ10: Narrow organisation: one mask, whole word
// RQ11: Output clock pins high select single-clock
// RQ12: Single-clock choice frozen after power-up
// RQ13: Ports deselect independently, bursts finish first
// RQ14: Impedance updates only in non-driving cycles
// RQ15: Controller gives 1024 non-read cycles first
// RQ16: Complementary echo pair toggles while running
// RQ17: After clock restart, 1024 cycles relock
// RQ18: Absent input clock resets the DLL
// RQ19: Stopped clock holds state; pending work finishes
// RQ20: Controller holds DLL hold low at power-up
// RQ21: Controller gives 2048 cycles for lock
// RQ22: Tied-high hold needs 30ns clock stop
// RQ23: Controller keeps clock above DLL minimum
// RQ24: Frequency change needs DLL reset, relock
// RQ25: Load enable low starts read burst
// RQ26: Read address taken at true edge
// RQ27: Middle organisation: second mask, upper nine
// RQ28: Read and write at same edge both proceed
module sram_burst_port
    import sram_burst_pkg::*;
#(
    parameter int DATA_W = 36,
    parameter int LANES  = 4,
    parameter int ADDR_W = ADDR_DEF
) (
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              storeEnB,
    input  wire logic              loadEnB,
    input  wire logic [ADDR_W-1:0] addrRise,
    input  wire logic [ADDR_W-1:0] addrFall,
    input  wire beat_t             beatRise,
    input  wire beat_t             beatFall,
    input  wire logic [1:0]        outClkPin,
    input  wire logic              clkPresent,
    input  wire logic              dllHoldB,
    input  wire logic [IMP_W-1:0]  impedanceSense,
    output var  readout_t          readOut,
    output logic                   readValid,
    output logic                   outEnable,
    output logic                   echoTiming,
    output logic                   echoTimingB,
    output logic [IMP_W-1:0]       drvCode,
    output logic                   singleClk,
    output logic                   dllLocked,
    output logic                   impedanceSettled
);

    localparam int LANE_W = DATA_W / LANES;
    localparam int MEM_N  = 2 ** (ADDR_W + 1);

    // =====================================================
    // Helpers

    // Merge a beat into a stored word lane by lane
    function automatic logic [DATA_W-1:0] laneMerge(
        input logic [DATA_W-1:0] old,
        input beat_t             b
    );
        logic [DATA_W-1:0] res;
        res = old;
        for (int l = 0; l < LANES; l++) begin
            if (!b.laneMaskB[l]) begin
                res[l*LANE_W +: LANE_W] = b.data[l*LANE_W +: LANE_W]; // see RQ8
            end
        end
        return res;
    endfunction

    // Word index of one beat inside a burst
    function automatic logic [ADDR_W:0] beatIdx(
        input logic [ADDR_W-1:0] a,
        input logic              beat
    );
        return {a, beat};
    endfunction

    // =====================================================
    // Pin synchronisers

    logic [2:0] pinLevel;
    logic       holdRel;
    logic       clkSeen;
    logic       outClkTied;

    pin_sync #(
        .W(3)
    ) u_pinSync (
        .core_clk(core_clk),
        .rst_b   (rst_b),
        .pinIn   ({&outClkPin, clkPresent, dllHoldB}),
        .level   (pinLevel)
    );

    assign holdRel    = pinLevel[0];
    assign clkSeen    = pinLevel[1];
    assign outClkTied = pinLevel[2];

    // =====================================================
    // Clock-stop detection

    logic [1:0] stopCnt_q;
    logic       clkStopped;
    logic       run;

    // Count cycles without input clock, saturating
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            stopCnt_q <= 2'h0;
        end else if (clkSeen) begin
            stopCnt_q <= 2'h0;
        end else if (stopCnt_q != STOP_CYC) begin
            stopCnt_q <= stopCnt_q + 2'h1;
        end
    end

    assign clkStopped = (stopCnt_q == STOP_CYC);
    assign run        = !clkStopped;

    // =====================================================
    // Single-clock strap

    logic [2:0] strapCnt_q;
    logic       singleClk_q;
    logic       strapDone;

    // Sample the tied-high pins until settled, then freeze
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            strapCnt_q  <= 3'h0;
            singleClk_q <= 1'b0;
        end else if (!strapDone) begin
            strapCnt_q  <= strapCnt_q + 3'h1;
            singleClk_q <= outClkTied; // see RQ11
        end
    end

    assign strapDone = (strapCnt_q == STRAP_WAIT); // see RQ12
    assign singleClk = singleClk_q;

    // =====================================================
    // Write path

    logic              wrPend_q;
    beat_t             wrFirst_q;
    logic [ADDR_W:0]   wrIdx0;
    logic [ADDR_W:0]   wrIdx1;
    logic [DATA_W-1:0] old0;
    logic [DATA_W-1:0] old1;
    logic [DATA_W-1:0] new0;
    logic [DATA_W-1:0] new1;
    logic [DATA_W-1:0] mem [MEM_N];

    // Command edge: hold the early word until the address
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wrPend_q  <= 1'b0;
            wrFirst_q <= '0;
        end else begin
            wrPend_q <= run && !storeEnB; // see RQ1 // see RQ7
            if (run && !storeEnB) begin
                wrFirst_q <= beatRise; // see RQ4 // see RQ6
            end
        end
    end

    // Burst addresses from the inverted-edge address
    assign wrIdx0 = beatIdx(addrFall, 1'b0); // see RQ2
    assign wrIdx1 = beatIdx(addrFall, 1'b1);
    assign old0   = mem[wrIdx0];
    assign old1   = mem[wrIdx1];
    assign new0   = laneMerge(old0, wrFirst_q); // see RQ9 // see RQ10 // see RQ27
    assign new1   = laneMerge(old1, beatFall); // see RQ5

    // Storage; a pending burst completes even at clock stop
    always_ff @(posedge core_clk) begin
        if (wrPend_q) begin
            mem[wrIdx0] <= new0; // see RQ3 // see RQ19
            mem[wrIdx1] <= new1;
        end
    end

    // =====================================================
    // Read path

    readout_t rdOut_q;
    logic     rdValid_q;

    // Read address at the true edge, independent of writes
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rdValid_q <= 1'b0;
            rdOut_q   <= '0;
        end else if (run) begin
            rdValid_q <= !loadEnB; // see RQ13 // see RQ25
            if (!loadEnB) begin
                rdOut_q.first  <= DATA_MAX'(mem[beatIdx(addrRise, 1'b0)]); // see RQ26 // see RQ28
                rdOut_q.second <= DATA_MAX'(mem[beatIdx(addrRise, 1'b1)]);
            end
        end
    end

    assign readOut   = rdOut_q;
    assign readValid = rdValid_q;
    assign outEnable = rdValid_q;

    // =====================================================
    // Echo clock pair

    logic echo_q;
    logic echoB_q;

    // Toggle every running cycle, hold while stopped
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            echo_q  <= 1'b0;
            echoB_q <= 1'b1;
        end else if (run) begin
            echo_q  <= !echo_q; // see RQ16
            echoB_q <= !echoB_q;
        end
    end

    assign echoTiming  = echo_q;
    assign echoTimingB = echoB_q;

    // =====================================================
    // Output impedance control

    logic [IMP_W-1:0] drvCode_q;
    logic [CNT_W-1:0] settleCnt_q;
    logic             quietCycle;

    // Neither driving now nor starting a read
    assign quietCycle = run && !rdValid_q && loadEnB;
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            drvCode_q <= DRV_RST;
        end else if (quietCycle) begin
            drvCode_q <= impedanceSense; // see RQ14
        end
    end

    // Count non-read cycles since reset
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            settleCnt_q <= '0;
        end else if (run && loadEnB && settleCnt_q != IMP_SETTLE_CYC) begin
            settleCnt_q <= settleCnt_q + 12'h001; // see RQ15
        end
    end

    assign drvCode          = drvCode_q;
    assign impedanceSettled = (settleCnt_q == IMP_SETTLE_CYC);

    // =====================================================
    // DLL lock sequencing

    dll_state_t       dllState_q;
    logic [CNT_W-1:0] dllCnt_q;
    logic             relock_q;
    logic [CNT_W-1:0] lockTarget;

    // Relock after a stop is shorter than first lock
    assign lockTarget = relock_q ? RESTART_CYC : LOCK_CYC;
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            dllState_q <= DLL_HELD;
            dllCnt_q   <= '0;
            relock_q   <= 1'b0;
        end else begin
            case (dllState_q)
                DLL_HELD: begin
                    dllCnt_q <= '0;
                    if (holdRel && run) begin
                        dllState_q <= DLL_LOCKING; // see RQ20
                    end
                end
                DLL_LOCKING: begin
                    if (!holdRel) begin
                        dllState_q <= DLL_HELD;
                        relock_q   <= 1'b0;
                    end else if (clkStopped) begin
                        dllState_q <= DLL_HELD; // see RQ18 // see RQ22
                        relock_q   <= 1'b1;
                    end else if (dllCnt_q == lockTarget - 12'h001) begin
                        dllState_q <= DLL_LOCKED; // see RQ17 // see RQ21
                    end else begin
                        dllCnt_q <= dllCnt_q + 12'h001;
                    end
                end
                DLL_LOCKED: begin
                    if (!holdRel) begin
                        dllState_q <= DLL_HELD;
                        relock_q   <= 1'b0;
                    end else if (clkStopped) begin
                        dllState_q <= DLL_HELD; // see RQ18 // see RQ24
                        relock_q   <= 1'b1;
                    end
                end
                default: begin
                    dllState_q <= DLL_HELD;
                end
            endcase
        end
    end

    assign dllLocked = (dllState_q == DLL_LOCKED);

    // =====================================================
    // Assertions

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // Write command, write deselect and read command at the true edge
    sequence wrCmdS;
        run && !storeEnB;
    endsequence
    sequence wrIdleS;
        run && storeEnB;
    endsequence
    sequence rdCmdS;
        run && !loadEnB;
    endsequence

    wr_early_a: assert property (wrCmdS |=> wrPend_q && wrFirst_q == $past(beatRise)) // see RQ4
        else $error("early write word not held");
    wr_deselect_a: assert property (wrIdleS |=> !wrPend_q && $stable(wrFirst_q)) // see RQ7
        else $error("deselected write took data");
    wr_burst_a: assert property (wrPend_q |=> mem[$past(wrIdx1)] == $past(new1)) // see RQ3
        else $error("second burst word not stored");
    wr_nomask_a: assert property (wrPend_q && (&wrFirst_q.laneMaskB[LANES-1:0])
        |=> mem[$past(wrIdx0)] == $past(old0)) // see RQ8
        else $error("masked beat changed memory");
    wr_stream_a: assert property (wrCmdS ##1 wrCmdS |-> wrPend_q ##1 wrPend_q) // see RQ6
        else $error("back-to-back write dropped");
    rd_burst_a: assert property (rdCmdS |=> readValid && outEnable) // see RQ25
        else $error("read burst not presented");
    rd_release_a: assert property (run && loadEnB && readValid |=> !outEnable) // see RQ13
        else $error("outputs driven after deselect");
    imp_quiet_a: assert property (outEnable |=> $stable(drvCode)) // see RQ14
        else $error("impedance changed while driving");
    echo_pair_a: assert property (run |=> echoTiming != $past(echoTiming) && echoTiming != echoTimingB) // see RQ16
        else $error("echo pair not toggling");
    stop_hold_a: assert property (clkStopped |=> $stable(readOut) && $stable(echoTiming)) // see RQ19
        else $error("outputs moved while stopped");
    dll_reset_a: assert property (clkStopped |=> !dllLocked) // see RQ18
        else $error("DLL kept lock without clock");
    dll_restart_a: assert property ($rose(dllLocked) |-> $past(dllCnt_q) == ($past(relock_q) ? RESTART_CYC : LOCK_CYC) - 12'h001) // see RQ17
        else $error("DLL locked early");
    strap_frozen_a: assert property (strapDone |=> $stable(singleClk)) // see RQ12
        else $error("single-clock mode changed");

endmodule
`default_nettype wire

//--- shared/sram_burst_pkg.sv
`default_nettype none
// =====================================================
// Burst-of-two port constants and carriers
package sram_burst_pkg;

    // Organisation limits and defaults
    localparam int DATA_MAX = 36;
    localparam int LANE_MAX = 4;
    localparam int ADDR_DEF = 20;
    localparam int IMP_W    = 4;
    localparam int CNT_W    = 12;

    // Timing: core clock period and least clock-stop time
    localparam int CLK_NS      = 25;
    localparam int STOP_MIN_NS = 30;
    localparam logic [1:0] STOP_CYC = 2'((STOP_MIN_NS + CLK_NS - 1) / CLK_NS);

    // Cycle counts for relock, first lock and impedance settle
    localparam logic [CNT_W-1:0] RESTART_CYC    = 12'h400;
    localparam logic [CNT_W-1:0] LOCK_CYC       = 12'h800;
    localparam logic [CNT_W-1:0] IMP_SETTLE_CYC = 12'h400;

    // Cycles after reset release until strap pins are settled
    localparam logic [2:0] STRAP_WAIT = 3'h6;

    // Reset value of the driver impedance code
    localparam logic [IMP_W-1:0] DRV_RST = 4'h8;

    // One data beat with its active-low lane masks
    typedef struct packed {
        logic [DATA_MAX-1:0] data;
        logic [LANE_MAX-1:0] laneMaskB;
    } beat_t;

    // Both words of one read burst
    typedef struct packed {
        logic [DATA_MAX-1:0] first;
        logic [DATA_MAX-1:0] second;
    } readout_t;

    // Delay-locked loop condition
    typedef enum logic [1:0] {
        DLL_HELD,
        DLL_LOCKING,
        DLL_LOCKED
    } dll_state_t;

endpackage
`default_nettype wire

//--- hw/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Three-stage pin synchroniser with agreement filter
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] level
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_q;
    logic [W-1:0] differ;

    // Stage chain; the first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a change once stages two and three agree
    assign differ = s2_q ^ s3_q;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            level_q <= '0;
        end else begin
            level_q <= (s2_q & ~differ) | (level_q & differ);
        end
    end

    assign level = level_q;

endmodule
`default_nettype wire

//--- tb/ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Controller side: commands, address, data, impedance code
module ctrl_model
    import sram_burst_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input  wire logic              core_clk,
    output logic                   storeEnB,
    output logic                   loadEnB,
    output logic [ADDR_W-1:0]      addrRise,
    output logic [ADDR_W-1:0]      addrFall,
    output var beat_t              beatRise,
    output var beat_t              beatFall,
    output logic [IMP_W-1:0]       impedanceSense
);
    logic              pendQ;
    logic [ADDR_W-1:0] pendA;
    beat_t             pendB;

    // Idle levels at time zero
    initial begin
        storeEnB = 1'b1;
        loadEnB = 1'b1;
        addrRise = '0;
        addrFall = '0;
        beatRise = '0;
        beatFall = '0;
        impedanceSense = 4'h8;
        pendQ = 1'b0;
    end

    // One input clock period; unused lines show the inverse of their last value
    task automatic cycle(input logic wr, input logic rd, input logic [ADDR_W-1:0] wa,
                         input logic [ADDR_W-1:0] ra, input beat_t b0, input beat_t b1,
                         input logic [IMP_W-1:0] imp);
        @(posedge core_clk);
        storeEnB <= !wr;
        loadEnB <= !rd;
        addrRise <= rd ? ra : ~addrRise;
        beatRise <= wr ? b0 : ~beatRise;
        addrFall <= pendQ ? pendA : ~addrFall;
        beatFall <= pendQ ? pendB : ~beatFall;
        impedanceSense <= imp;
        pendQ <= wr;
        pendA <= wa;
        pendB <= b1;
    endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Bench for the burst-of-two port
module tb_top;
    import sram_burst_pkg::*;
    localparam int AW = 4;
    logic            core_clk = 1'b0;
    logic            rst_b = 1'b0;
    logic            clkPresent = 1'b1;
    logic            dllHoldB = 1'b0;
    logic [1:0]      outClkPin = 2'b11;
    logic            storeEnB, loadEnB, readValid, outEnable, echoTiming, echoTimingB;
    logic            singleClk, dllLocked, impedanceSettled, expValid, wrPend, lastEcho;
    logic [AW-1:0]   addrRise, addrFall;
    beat_t           beatRise, beatFall, w0;
    logic [IMP_W-1:0] impedanceSense, drvCode, expDrv;
    readout_t        readOut, expRd;
    logic [35:0]     mem [0:31];
    logic            stopped = 1'b0;
    logic            checkOn = 1'b0;
    logic            varyImp = 1'b0;
    integer          seed = 32'h0e79;
    int              failures = 0;
    int              cmp_count = 0;
    int              n;

    always #12.5 core_clk = ~core_clk;

    ctrl_model #(.ADDR_W(AW)) i_ctrl (.core_clk(core_clk), .storeEnB(storeEnB), .loadEnB(loadEnB),
        .addrRise(addrRise), .addrFall(addrFall), .beatRise(beatRise), .beatFall(beatFall),
        .impedanceSense(impedanceSense));

    sram_burst_port #(.DATA_W(36), .LANES(4), .ADDR_W(AW)) i_dut (.core_clk(core_clk), .rst_b(rst_b),
        .storeEnB(storeEnB), .loadEnB(loadEnB), .addrRise(addrRise), .addrFall(addrFall),
        .beatRise(beatRise), .beatFall(beatFall), .outClkPin(outClkPin), .clkPresent(clkPresent),
        .dllHoldB(dllHoldB), .impedanceSense(impedanceSense), .readOut(readOut), .readValid(readValid),
        .outEnable(outEnable), .echoTiming(echoTiming), .echoTimingB(echoTimingB), .drvCode(drvCode),
        .singleClk(singleClk), .dllLocked(dllLocked), .impedanceSettled(impedanceSettled));

    // Lane-masked merge of one beat into a stored word
    function automatic logic [35:0] merge(input logic [35:0] old, input beat_t b);
        merge = old;
        for (int l = 0; l < 4; l++)
            if (!b.laneMaskB[l])
                merge[l*9 +: 9] = b.data[l*9 +: 9];
    endfunction

    // Reference model: array, read path and impedance code
    always @(posedge core_clk) begin
        if (!rst_b) begin
            expValid = 1'b0;
            expDrv = DRV_RST;
            wrPend = 1'b0;
        end else if (!stopped) begin
            if (!expValid && loadEnB)
                expDrv = impedanceSense;
            expValid = !loadEnB;
            if (!loadEnB) begin
                expRd.first = mem[{addrRise, 1'b0}];
                expRd.second = mem[{addrRise, 1'b1}];
            end
            if (wrPend) begin
                mem[{addrFall, 1'b0}] = merge(mem[{addrFall, 1'b0}], w0);
                mem[{addrFall, 1'b1}] = merge(mem[{addrFall, 1'b1}], beatFall);
            end
            wrPend = !storeEnB;
            w0 = beatRise;
        end
    end

    // Output comparisons where outputs are settled
    always @(negedge core_clk) begin
        if (rst_b && checkOn) begin
            check(readValid, expValid);
            check(outEnable, expValid);
            if (expValid)
                check(readOut, expRd);
            check(drvCode, expDrv);
            check(echoTimingB, !echoTiming);
            check(echoTiming, !lastEcho);
        end
        lastEcho <= echoTiming;
    end

    task automatic check(input logic [71:0] seen, input logic [71:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    function automatic beat_t rb(input logic [3:0] m);
        logic [63:0] r;
        r = {$random(seed), $random(seed)};
        rb.data = r[35:0];
        rb.laneMaskB = m;
    endfunction

    function automatic logic [3:0] r4();
        logic [31:0] r;
        r = $random(seed);
        r4 = r[3:0];
    endfunction

    task automatic op(input logic wr, input logic rd, input int wa, input int ra, input logic [3:0] m);
        i_ctrl.cycle(wr, rd, AW'(wa), AW'(ra), rb(m), rb(m), varyImp ? r4() : 4'h8);
    endtask

    // Idle cycles until the loop locks, with a bound
    task automatic waitLock(output int cnt);
        cnt = 0;
        while (dllLocked !== 1'b1 && cnt < 3000) begin
            op(0, 0, 0, 0, 4'h0);
            #2;
            cnt++;
        end
        if (cnt >= 3000) begin
            failures++;
            wrap_up();
        end
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (8) op(0, 0, 0, 0, 4'h0);
        #2;
        check(drvCode, DRV_RST);
        check(dllLocked, 1'b0);
        check(impedanceSettled, 1'b0);
        check(singleClk, 1'b1);
        checkOn = 1'b1;
        varyImp = 1'b1;
        dllHoldB <= 1'b1;
        waitLock(n);
        check(n >= 2048 && n <= 2060, 1'b1);
        check(impedanceSettled, 1'b1);
        for (int a = 0; a < 16; a++)
            op(1, 0, a, 0, 4'h0);
        for (int a = 0; a < 16; a++)
            op(0, 1, 0, a, 4'h0);
        for (int i = 0; i < 16; i++) begin
            op(1, 0, i, 0, i == 0 ? 4'b0011 : (i == 1 ? 4'hf : r4()));
            if (i[0])
                op(0, 0, 0, 0, 4'h0);
        end
        op(1, 1, 5, 5, 4'h0);
        for (int a = 0; a < 16; a++)
            op(0, 1, 0, a, 4'h0);
        outClkPin <= 2'b00;
        varyImp = 1'b0;
        repeat (4) op(0, 0, 0, 0, 4'h0);
        #2;
        check(singleClk, 1'b1);
        checkOn = 1'b0;
        stopped = 1'b1;
        clkPresent <= 1'b0;
        repeat (10) op(0, 0, 0, 0, 4'h0);
        #2;
        check(dllLocked, 1'b0);
        op(1, 0, 0, 0, 4'h0);
        repeat (10) op(0, 0, 0, 0, 4'h0);
        clkPresent <= 1'b1;
        waitLock(n);
        check(n >= 1024 && n <= 1040, 1'b1);
        stopped = 1'b0;
        checkOn = 1'b1;
        op(0, 1, 0, 0, 4'h0);
        repeat (3) op(0, 0, 0, 0, 4'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
